// File: logic/mpwm_pkg.sv
// constants and types shared by the multiphase interleaver files
`default_nettype none
package mpwm_pkg;
   // timing, all figures in their own units first
   localparam int CLK_PERIOD_NS = 25;
   localparam int SW_PERIOD_NS  = 6000;
   localparam int SW_PERIOD_INT = SW_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [7:0] SW_PERIOD_CYC = 8'(SW_PERIOD_INT);
   // least times round up to whole cycles
   localparam logic [7:0] FORCED_OFF_CYC = 8'((SW_PERIOD_INT + 2) / 3);
   localparam logic [7:0] SAMPLE_START_CYC = 8'((SW_PERIOD_INT + 5) / 6);
   localparam logic [7:0] SAMPLE_END_CYC =
      8'((SW_PERIOD_INT + 5) / 6 + (SW_PERIOD_INT + 2) / 3);
   // termination offsets inside one period, per phase count
   localparam logic [7:0] T4_OFS_4 = 8'h00;
   localparam logic [7:0] T4_OFS_3 = 8'(SW_PERIOD_INT / 4);
   localparam logic [7:0] T4_OFS_2 = 8'(SW_PERIOD_INT / 2);
   localparam logic [7:0] T4_OFS_1 = 8'(3 * SW_PERIOD_INT / 4);
   localparam logic [7:0] T3_OFS_3 = 8'h00;
   localparam logic [7:0] T3_OFS_2 = 8'(SW_PERIOD_INT / 3);
   localparam logic [7:0] T3_OFS_1 = 8'(2 * SW_PERIOD_INT / 3);
   localparam logic [7:0] T2_OFS_1 = 8'h00;
   localparam logic [7:0] T2_OFS_2 = 8'(SW_PERIOD_INT / 2);
   // strap release time before the straps are read
   localparam logic [3:0] STRAP_SETTLE_CYC = 4'h8;
   // phase counts
   localparam logic [2:0] PHASES_2 = 3'h2;
   localparam logic [2:0] PHASES_3 = 3'h3;
   localparam logic [2:0] PHASES_4 = 3'h4;
   localparam logic [7:0] SAMPLE_RESET = 8'h00;

   typedef enum logic [1:0] {CH_WAIT, CH_OFF, CH_ARMED, CH_HIGH}
      mpwm_ch_state_t;
   typedef enum logic {ST_RELEASE, ST_RUN} mpwm_strap_t;
endpackage
`default_nettype wire

// File: logic/mpwm_channel.sv
// one phase channel: forced off, comparator rise, sample and hold
`timescale 1ns/1ps
`default_nettype none
module mpwm_channel (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       enable,
   input  wire logic       term_tick,
   input  wire logic       ramp_cross,
   input  wire logic [7:0] sense_in,
   output logic            phase_out,
   output logic            sampling,
   output logic [7:0]      held_sample
);
   mpwm_pkg::mpwm_ch_state_t state_reg;
   logic [7:0] off_cnt_reg;
   logic [7:0] track_reg;
   logic [7:0] held_reg;
   logic [7:0] low_cnt_reg;
   logic       phase_reg;
   logic       window_d_reg;
   logic       in_window;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_reg <= mpwm_pkg::CH_WAIT;
      end else if (!enable) begin
         state_reg <= mpwm_pkg::CH_WAIT;
      end else if (term_tick) begin
         state_reg <= mpwm_pkg::CH_OFF;
      end else begin
         unique case (state_reg)
            mpwm_pkg::CH_WAIT: state_reg <= mpwm_pkg::CH_WAIT;
            mpwm_pkg::CH_OFF: begin
               if (off_cnt_reg == mpwm_pkg::FORCED_OFF_CYC - 8'h01) begin
                  state_reg <= mpwm_pkg::CH_ARMED;
               end
            end
            mpwm_pkg::CH_ARMED: begin
               if (ramp_cross) begin
                  state_reg <= mpwm_pkg::CH_HIGH;
               end
            end
            mpwm_pkg::CH_HIGH: state_reg <= mpwm_pkg::CH_HIGH;
         endcase
      end
   end

   // output flop mirrors the high state so the pin never glitches
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         phase_reg <= 1'b0;
      end else if (!enable || term_tick) begin
         phase_reg <= 1'b0;
      end else if (state_reg == mpwm_pkg::CH_ARMED && ramp_cross) begin
         phase_reg <= 1'b1;
      end
   end

   // off-time counter saturates at the window end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         off_cnt_reg <= 8'h00;
      end else if (term_tick) begin
         off_cnt_reg <= 8'h00;
      end else if ((state_reg == mpwm_pkg::CH_OFF
                    || state_reg == mpwm_pkg::CH_ARMED)
                   && off_cnt_reg < mpwm_pkg::SAMPLE_END_CYC) begin
         off_cnt_reg <= off_cnt_reg + 8'h01;
      end
   end

   assign in_window = (state_reg == mpwm_pkg::CH_OFF
                       || state_reg == mpwm_pkg::CH_ARMED)
                      && off_cnt_reg >= mpwm_pkg::SAMPLE_START_CYC
                      && off_cnt_reg < mpwm_pkg::SAMPLE_END_CYC;

   // track through the window, hold the last value until the next end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         track_reg    <= mpwm_pkg::SAMPLE_RESET;
         held_reg     <= mpwm_pkg::SAMPLE_RESET;
         window_d_reg <= 1'b0;
      end else if (!enable) begin
         track_reg    <= mpwm_pkg::SAMPLE_RESET;
         held_reg     <= mpwm_pkg::SAMPLE_RESET;
         window_d_reg <= 1'b0;
      end else begin
         window_d_reg <= in_window;
         if (in_window) begin
            track_reg <= sense_in;
         end
         if (window_d_reg && !in_window) begin
            held_reg <= track_reg;
         end
      end
   end

   assign phase_out   = phase_reg;
   assign sampling    = window_d_reg;
   assign held_sample = held_reg;

   // helper: cycles the output has been low
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         low_cnt_reg <= 8'h00;
      end else if (phase_reg || term_tick) begin
         low_cnt_reg <= 8'h00;
      end else if (low_cnt_reg != 8'hFF) begin
         low_cnt_reg <= low_cnt_reg + 8'h01;
      end
   end

   property p_forced_off;
      @(posedge ref_clk) disable iff (rst)
      $rose(phase_reg) |-> low_cnt_reg > mpwm_pkg::FORCED_OFF_CYC;
   endproperty
   a_forced_off: assert property (p_forced_off)
      else $error("phase rose before forced off time");

   property p_window_low;
      @(posedge ref_clk) disable iff (rst)
      $rose(window_d_reg) |-> !phase_reg
         && off_cnt_reg == mpwm_pkg::SAMPLE_START_CYC + 8'h01;
   endproperty
   a_window_low: assert property (p_window_low)
      else $error("sample window opened at wrong time");

   property p_hold;
      @(posedge ref_clk) disable iff (rst)
      enable && !$past(window_d_reg) |-> $stable(held_reg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("held sample changed outside window end");

   c_rise: cover property (@(posedge ref_clk) disable iff (rst)
      $rose(phase_reg));
endmodule // mpwm_channel
`default_nettype wire

// File: logic/mpwm_interleaver.sv
// multiphase interleaver top: straps, termination clock, four channels
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - active phases are spaced evenly, a third cycle apart in three phase mode
// - with no strap found, all four channels run
// - a termination tick once per period drives a phase low, opening its cycle
// - four phases terminate in order 4,3,2,1, quarter cycle apart
// - output 4 tied high with output 3 low gives three phases, order 3,2,1, third cycle apart
// - output 3 strapped high gives two phases, phase 2 half cycle after 1
// - a phase that falls stays low at least one third cycle
// - after forced off, the comparator trip drives the phase high
// - a high phase stays high until its next termination tick
// - sampling starts a sixth period after the fall, lasts a third or to rise
// - each captured sample is held for one full switching cycle
// - sampling is per channel; strapped-off channels are disabled
module mpwm_interleaver (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       ramp_cross_1,
   input  wire logic       ramp_cross_2,
   input  wire logic       ramp_cross_3,
   input  wire logic       ramp_cross_4,
   input  wire logic [7:0] sensed_channel_current_1,
   input  wire logic [7:0] sensed_channel_current_2,
   input  wire logic [7:0] sensed_channel_current_3,
   input  wire logic [7:0] sensed_channel_current_4,
   input  wire logic       phase_out_3_strap_in,
   input  wire logic       phase_out_4_strap_in,
   output logic            phase_out_1,
   output logic            phase_out_2,
   output logic            phase_out_3_strap_out,
   output logic            phase_out_3_strap_oe,
   output logic            phase_out_4_strap_out,
   output logic            phase_out_4_strap_oe,
   output logic [2:0]      phase_count,
   output logic [7:0]      held_current_1,
   output logic [7:0]      held_current_2,
   output logic [7:0]      held_current_3,
   output logic [7:0]      held_current_4,
   output logic [3:0]      sampling
);
   localparam int D_QUARTER = mpwm_pkg::SW_PERIOD_INT / 4;
   localparam int D_THIRD   = mpwm_pkg::SW_PERIOD_INT / 3;
   localparam int D_HALF    = mpwm_pkg::SW_PERIOD_INT / 2;
   localparam int D_TWO3    = 2 * (mpwm_pkg::SW_PERIOD_INT / 3);
   localparam int D_PERIOD  = mpwm_pkg::SW_PERIOD_INT;

   mpwm_pkg::mpwm_strap_t strap_state_reg;
   logic [3:0] settle_cnt_reg;
   logic [2:0] phase_count_reg;
   logic [7:0] period_cnt_reg;
   logic [3:0] ch_enable;
   logic [3:0] term_tick;
   logic [3:0] ch_phase;
   logic [3:0] ramp_cross;
   logic [7:0] sense [4];
   logic [7:0] held [4];
   logic       running;

   // offset of a channel's termination inside the period
   function automatic logic [7:0] tick_offset(input logic [2:0] n,
                                              input int ch);
      logic [7:0] ofs;
      ofs = 8'h00;
      if (n == mpwm_pkg::PHASES_4) begin
         unique case (ch)
            0: ofs = mpwm_pkg::T4_OFS_1;
            1: ofs = mpwm_pkg::T4_OFS_2;
            2: ofs = mpwm_pkg::T4_OFS_3;
            default: ofs = mpwm_pkg::T4_OFS_4;
         endcase
      end else if (n == mpwm_pkg::PHASES_3) begin
         unique case (ch)
            0: ofs = mpwm_pkg::T3_OFS_1;
            1: ofs = mpwm_pkg::T3_OFS_2;
            default: ofs = mpwm_pkg::T3_OFS_3;
         endcase
      end else begin
         ofs = (ch == 0) ? mpwm_pkg::T2_OFS_1 : mpwm_pkg::T2_OFS_2;
      end
      return ofs;
   endfunction

   // straps are released, read once, then frozen until reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         strap_state_reg <= mpwm_pkg::ST_RELEASE;
         settle_cnt_reg  <= 4'h0;
         phase_count_reg <= mpwm_pkg::PHASES_4;
      end else if (strap_state_reg == mpwm_pkg::ST_RELEASE) begin
         settle_cnt_reg <= settle_cnt_reg + 4'h1;
         if (settle_cnt_reg == mpwm_pkg::STRAP_SETTLE_CYC - 4'h1) begin
            strap_state_reg <= mpwm_pkg::ST_RUN;
            if (phase_out_3_strap_in) begin
               phase_count_reg <= mpwm_pkg::PHASES_2;
            end else if (phase_out_4_strap_in) begin
               phase_count_reg <= mpwm_pkg::PHASES_3;
            end else begin
               phase_count_reg <= mpwm_pkg::PHASES_4;
            end
         end
      end
   end

   assign running = (strap_state_reg == mpwm_pkg::ST_RUN);

   // single period counter shared by all phases keeps them locked
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         period_cnt_reg <= 8'h00;
      end else if (!running) begin
         period_cnt_reg <= 8'h00;
      end else if (period_cnt_reg == mpwm_pkg::SW_PERIOD_CYC - 8'h01) begin
         period_cnt_reg <= 8'h00;
      end else begin
         period_cnt_reg <= period_cnt_reg + 8'h01;
      end
   end

   assign ch_enable[0] = running;
   assign ch_enable[1] = running;
   assign ch_enable[2] = running && phase_count_reg >= mpwm_pkg::PHASES_3;
   assign ch_enable[3] = running && phase_count_reg == mpwm_pkg::PHASES_4;

   assign ramp_cross = {ramp_cross_4, ramp_cross_3,
                        ramp_cross_2, ramp_cross_1};
   assign sense[0] = sensed_channel_current_1;
   assign sense[1] = sensed_channel_current_2;
   assign sense[2] = sensed_channel_current_3;
   assign sense[3] = sensed_channel_current_4;

   for (genvar i = 0; i < 4; i++) begin : g_ch
      assign term_tick[i] = ch_enable[i]
         && period_cnt_reg == tick_offset(phase_count_reg, i);
      mpwm_channel u_ch (
         .ref_clk     (ref_clk),
         .rst         (rst),
         .enable      (ch_enable[i]),
         .term_tick   (term_tick[i]),
         .ramp_cross  (ramp_cross[i]),
         .sense_in    (sense[i]),
         .phase_out   (ch_phase[i]),
         .sampling    (sampling[i]),
         .held_sample (held[i])
      );
   end

   assign phase_out_1           = ch_phase[0];
   assign phase_out_2           = ch_phase[1];
   assign phase_out_3_strap_out = ch_phase[2];
   // strapped pins are never driven, so a tie to supply is not fought
   assign phase_out_3_strap_oe  = ch_enable[2];
   assign phase_out_4_strap_out = ch_phase[3];
   assign phase_out_4_strap_oe  = ch_enable[3];
   assign phase_count           = phase_count_reg;
   assign held_current_1        = held[0];
   assign held_current_2        = held[1];
   assign held_current_3        = held[2];
   assign held_current_4        = held[3];

   property p_order4;
      @(posedge ref_clk) disable iff (rst)
      phase_count_reg == mpwm_pkg::PHASES_4 && term_tick[3]
         |-> ##D_QUARTER term_tick[2] ##D_QUARTER term_tick[1]
             ##D_QUARTER term_tick[0];
   endproperty
   a_order4: assert property (p_order4)
      else $error("four phase firing order or spacing wrong");

   property p_order3;
      @(posedge ref_clk) disable iff (rst)
      phase_count_reg == mpwm_pkg::PHASES_3 && term_tick[2]
         |-> ##D_THIRD term_tick[1] ##D_THIRD term_tick[0];
   endproperty
   a_order3: assert property (p_order3)
      else $error("three phase firing order or spacing wrong");

   property p_sym3;
      @(posedge ref_clk) disable iff (rst)
      phase_count_reg == mpwm_pkg::PHASES_3 && term_tick[2]
         |-> ##D_TWO3 term_tick[0] && !term_tick[3];
   endproperty
   a_sym3: assert property (p_sym3)
      else $error("three phase channels not evenly spaced");

   property p_order2;
      @(posedge ref_clk) disable iff (rst)
      phase_count_reg == mpwm_pkg::PHASES_2 && term_tick[0]
         |-> ##D_HALF term_tick[1];
   endproperty
   a_order2: assert property (p_order2)
      else $error("two phase spacing wrong");

   property p_period;
      @(posedge ref_clk) disable iff (rst)
      term_tick[0] |-> ##D_PERIOD term_tick[0];
   endproperty
   a_period: assert property (p_period)
      else $error("termination period wrong");

   property p_tick_low;
      @(posedge ref_clk) disable iff (rst)
      term_tick[1] |=> !phase_out_2;
   endproperty
   a_tick_low: assert property (p_tick_low)
      else $error("termination tick did not drive phase low");

   property p_stay_high;
      @(posedge ref_clk) disable iff (rst)
      phase_out_1 && !term_tick[0] |=> phase_out_1;
   endproperty
   a_stay_high: assert property (p_stay_high)
      else $error("phase fell without termination tick");

   property p_default;
      @(posedge ref_clk) disable iff (rst)
      $rose(running) && !$past(phase_out_3_strap_in)
         && !$past(phase_out_4_strap_in)
         |-> phase_count_reg == mpwm_pkg::PHASES_4;
   endproperty
   a_default: assert property (p_default)
      else $error("default phase count is not four");

   property p_frozen;
      @(posedge ref_clk) disable iff (rst)
      running && $past(running) |-> $stable(phase_count_reg);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("phase count changed while running");

   property p_inactive;
      @(posedge ref_clk) disable iff (rst)
      phase_count_reg != mpwm_pkg::PHASES_4
         |-> !phase_out_4_strap_oe && held_current_4 == 8'h00;
   endproperty
   a_inactive: assert property (p_inactive)
      else $error("strapped-off channel is active");

   c_four: cover property (@(posedge ref_clk) disable iff (rst)
      running && phase_count_reg == mpwm_pkg::PHASES_4 && term_tick[0]);
   c_three: cover property (@(posedge ref_clk) disable iff (rst)
      running && phase_count_reg == mpwm_pkg::PHASES_3 && term_tick[0]);
   c_two: cover property (@(posedge ref_clk) disable iff (rst)
      running && phase_count_reg == mpwm_pkg::PHASES_2 && term_tick[1]);
endmodule // mpwm_interleaver
`default_nettype wire

// File: test/mpwm_drv_model.sv
// driver-chip side model: strap ties and pin levels of outputs 3 and 4
`timescale 1ns/1ps
`default_nettype none
module mpwm_drv_model (
   input  wire logic tie_3,
   input  wire logic tie_4,
   input  wire logic out_3,
   input  wire logic oe_3,
   input  wire logic out_4,
   input  wire logic oe_4,
   output logic      pin_3,
   output logic      pin_4
);
   // undriven pin shows the board tie; an untied driver input has a
   // pull-down, so a released pin never floats high by accident
   always_comb begin
      pin_3 = oe_3 ? out_3 : tie_3;
      pin_4 = oe_4 ? out_4 : tie_4;
   end
endmodule // mpwm_drv_model
`default_nettype wire

// File: test/testbench.sv
// self-checking bench for the multiphase interleaver
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct {int ch; int gap;} mpwm_note_t;
   localparam int P = 240;
   logic            ref_clk = 1'b0;
   logic            rst = 1'b1;
   logic [3:0]      ramp = 4'h0;
   logic [3:0][7:0] sense = '0;
   wire [3:0][7:0]  held;
   logic [3:0][7:0] held_q = '0;
   logic            tie_3 = 1'b0;
   logic            tie_4 = 1'b0;
   logic            pin_3, pin_4, p1, p2, o3, e3, o4, e4;
   logic [2:0]      phase_count;
   logic [3:0]      sampling, ph;
   logic [3:0]      ph_q = 4'h0, samp_q = 4'h0, ramp_q = 4'h0;
   logic [3:0]      upd = 4'h0;
   logic [3:0][7:0] sense_q1 = '0, sense_q2 = '0;
   int              gap = 0;
   bit              in_time = 1'b0;
   logic [3:0]      en = 4'hf;
   mpwm_note_t      notes [$];
   mpwm_note_t      nt;
   int              fall_t [4] = '{-1, -1, -1, -1};
   int              rise_t [4] = '{0, 0, 0, 0};
   int              samp_t [4] = '{0, 0, 0, 0};
   int              last_fall = 0;
   int              cyc = 0;
   int              err_total = 0;
   int              samples_checked = 0;
   bit              chk_on = 1'b0;

   always #12.5 ref_clk = ~ref_clk;

   mpwm_interleaver mpwm_interleaver_inst (
      .ref_clk(ref_clk), .rst(rst),
      .ramp_cross_1(ramp[0]), .ramp_cross_2(ramp[1]),
      .ramp_cross_3(ramp[2]), .ramp_cross_4(ramp[3]),
      .sensed_channel_current_1(sense[0]),
      .sensed_channel_current_2(sense[1]),
      .sensed_channel_current_3(sense[2]),
      .sensed_channel_current_4(sense[3]),
      .phase_out_3_strap_in(pin_3), .phase_out_4_strap_in(pin_4),
      .phase_out_1(p1), .phase_out_2(p2),
      .phase_out_3_strap_out(o3), .phase_out_3_strap_oe(e3),
      .phase_out_4_strap_out(o4), .phase_out_4_strap_oe(e4),
      .phase_count(phase_count),
      .held_current_1(held[0]), .held_current_2(held[1]),
      .held_current_3(held[2]), .held_current_4(held[3]),
      .sampling(sampling));

   mpwm_drv_model mpwm_drv_model_inst (
      .tie_3(tie_3), .tie_4(tie_4), .out_3(o3), .oe_3(e3),
      .out_4(o4), .oe_4(e4), .pin_3(pin_3), .pin_4(pin_4));

   task automatic chk8(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic chk_int(input string what, input int exp, input int got);
      samples_checked++;
      if (got != exp) begin
         err_total++;
         $display("Error %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // comparator trips arrive at random, a quarter of the cycles
   always @(posedge ref_clk) begin
      for (int k = 0; k < 4; k++) begin
         ramp[k] <= ($urandom % 4) == 0;
         sense[k] <= 8'($urandom);
      end
   end

   // monitor: falls against the notes, rises, windows and held values
   always @(posedge ref_clk) begin
      #1;
      cyc++;
      ph = {o4, o3, p2, p1};
      for (int k = 0; k < 4; k++) begin
         // held value moves on the same edge that closes the window
         upd[k] = chk_on && samp_q[k] && !sampling[k];
         if (chk_on && ph_q[k] && !ph[k]) begin
            if (notes.size() == 0) begin
               chk_int("fall_extra", 0, k + 1);
            end else begin
               nt = notes.pop_front();
               chk_int("fall_channel", nt.ch, k + 1);
               if (nt.gap >= 0) begin
                  gap = cyc - last_fall;
                  chk_int("fall_gap", nt.gap, gap);
               end
               if (fall_t[k] >= 0) begin
                  chk_int("fall_period", P, cyc - fall_t[k]);
               end
            end
            last_fall = cyc;
            fall_t[k] = cyc;
         end
         if (chk_on && !ph_q[k] && ph[k]) begin
            chk8("rise_cause", 8'h01, {7'h00, ramp_q[k]});
            if (fall_t[k] >= 0) begin
               in_time = cyc - fall_t[k] >= P / 3;
               chk_int("forced_off", 1, int'(in_time));
            end
            rise_t[k] = cyc;
         end
         if (chk_on && !samp_q[k] && sampling[k]) begin
            if (fall_t[k] >= 0) begin
               chk_int("window_start", P / 6 + 1, cyc - fall_t[k]);
            end
            samp_t[k] = cyc;
         end
         if (upd[k]) begin
            in_time = cyc - samp_t[k] <= P / 3;
            chk_int("window_len", 1, int'(in_time));
            // a rise on the closing edge itself did not cut the window
            if (rise_t[k] > samp_t[k] && rise_t[k] < cyc) begin
               chk_int("window_cut", 1, cyc - rise_t[k]);
            end
            // last in-window sense value was driven two edges ago
            chk8("held_value", sense_q2[k], held[k]);
         end else if (chk_on) begin
            chk8("held_keep", held_q[k], held[k]);
         end
         if (chk_on && !en[k]) begin
            chk8("off_held", 8'h00, held[k]);
            chk8("off_samp", 8'h00, {7'h00, sampling[k]});
         end
      end
      ph_q = ph;
      samp_q = sampling;
      ramp_q = ramp;
      held_q = held;
      sense_q2 = sense_q1;
      sense_q1 = sense;
   end

   // one strap setting: reset, strap read, six periods of firing order
   task automatic run(input logic t3, input logic t4, input int n);
      int order [4];
      int w;
      @(posedge ref_clk);
      chk_on = 1'b0;
      rst <= 1'b1;
      tie_3 <= t3;
      tie_4 <= t4;
      @(posedge ref_clk);
      #1;
      chk8("reset_outputs", 8'h00, {2'h0, p1, p2, o3, o4, e3, e4});
      chk8("reset_count", 8'h04, {5'h00, phase_count});
      @(posedge ref_clk);
      rst <= 1'b0;
      notes.delete();
      fall_t = '{-1, -1, -1, -1};
      en = (n == 4) ? 4'hf : (n == 3) ? 4'h7 : 4'h3;
      if (n == 4) begin
         order = '{4, 3, 2, 1};
      end else if (n == 3) begin
         order = '{3, 2, 1, 0};
      end else begin
         order = '{1, 2, 0, 0};
      end
      repeat (8) @(posedge ref_clk);
      #1;
      chk8("phase_count", 8'(n), {5'h00, phase_count});
      chk8("oe_3", {7'h00, en[2]}, {7'h00, e3});
      chk8("oe_4", {7'h00, en[3]}, {7'h00, e4});
      for (int i = 0; i < 6 * n; i++) begin
         nt.ch = order[i % n];
         nt.gap = (i == 0) ? -1 : P / n;
         notes.push_back(nt);
      end
      chk_on = 1'b1;
      for (w = 0; w < 8 * P && notes.size() > 0; w++) begin
         @(posedge ref_clk);
         // late strap changes must not move the phase count
         if (w == 3 * P) begin
            tie_3 <= ~t3;
            tie_4 <= ~t4;
         end
      end
      chk_on = 1'b0;
      if (notes.size() > 0) begin
         err_total++;
         $display("Error fall_wait expected 0 seen %0d", notes.size());
         conclude();
      end
      chk8("phase_count_kept", 8'(n), {5'h00, phase_count});
   endtask

   initial begin
      void'($urandom(25127));
      repeat (2) @(posedge ref_clk);
      run(1'b0, 1'b0, 4);
      run(1'b0, 1'b1, 3);
      run(1'b1, 1'b0, 2);
      run(1'b1, 1'b1, 2);
      conclude();
   end
endmodule // testbench
`default_nettype wire
